// ==== thermal_protection_supervisor.sv ====
/*
  Three-level thermal protection: per-stage shutdown, main supply prewarning,
  device shutdown with cool-down sequence, plus main supply OV and short filters.
  Assumes comparator inputs are already synchronous to clk_sys; software clears
  flags by one-cycle clear pulses from the serial interface.
*/
// How it works
// - Hot stage switched off alone, except high-side switches (all off together), flag set
// - Stage flag sticky, clear only when cool
// - Stage detection only while stage on
// - Second regulator off, enables cleared, flagged
// - Standalone third regulator off, enables cleared
// - Load-sharing third regulator auto restarts
// - CAN transmitter off, failure field 01
// - LIN transmitter off, failure field 01
// - Any hot switch turns all off
// - Diagnosis bits never self-clear
// - Prewarning only sets flag, clear when cool
// - Prewarning detection only with main supply
// - Device shutdown: fail-safe, restart, normal
// - Device flag clear in normal, when cool
// - Device detection only with main supply
// - Overvoltage filtered for filter time
// - Short detected after short filter time
`timescale 1ns/1ps
`default_nettype none
module thermal_protection_supervisor #(
  parameter int unsigned COOLDOWN_CYCLES = thermal_pkg::COOLDOWN_CYC,
  parameter int unsigned RESTART_CYCLES = thermal_pkg::RESTART_CYC,
  parameter int unsigned SHORT_CYCLES = thermal_pkg::SHORT_FILTER_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire thermal_pkg::overtemp_t overtemp_raw,
  input wire logic main_supply_on,
  input wire logic main_supply_ov_raw,
  input wire logic main_supply_below_reset_raw,
  input wire logic third_reg_load_share,
  input wire logic second_reg_enable_set,
  input wire logic third_reg_enable_set,
  input wire logic [thermal_pkg::NUM_HS-1:0] highside_control_set,
  input wire logic can_tx_request,
  input wire logic [thermal_pkg::NUM_LIN-1:0] lin_tx_request,
  input wire thermal_pkg::status_t status_clear,
  input wire logic can_fail_clear,
  input wire logic [thermal_pkg::NUM_LIN-1:0] lin_fail_clear,
  output var thermal_pkg::status_t status_q,
  output logic second_reg_enable_q,
  output logic third_reg_enable_q,
  output logic third_reg_on_q,
  output logic [thermal_pkg::NUM_HS-1:0] highside_control_q,
  output logic can_tx_enable_q,
  output logic [thermal_pkg::NUM_LIN-1:0] lin_tx_enable_q,
  output logic [1:0] can_failure_status_q,
  output logic [2*thermal_pkg::NUM_LIN-1:0] lin_failure_status_q,
  output var thermal_pkg::mode_t mode_q,
  output logic main_supply_ov_q,
  output logic main_supply_short_q
);
  import thermal_pkg::*;

  // Elaboration checks
  if (COOLDOWN_CYCLES < 1 || RESTART_CYCLES < 1 || SHORT_CYCLES < 1)
  begin : g_bad_count
    $error("Timing counts must be at least one cycle");
  end

  localparam int unsigned CW = $clog2(COOLDOWN_CYCLES + RESTART_CYCLES + 1);
  localparam int unsigned SW = $clog2(SHORT_CYCLES + 1);
  localparam int unsigned OW = $clog2(OV_FILTER_CYC + 1);
  localparam logic [CW-1:0] COOL_LAST = CW'(COOLDOWN_CYCLES - 1);
  localparam logic [CW-1:0] RESTART_LAST = CW'(RESTART_CYCLES - 1);
  localparam logic [SW-1:0] SHORT_LAST = SW'(SHORT_CYCLES - 1);
  localparam logic [OW-1:0] OV_LAST = OW'(OV_FILTER_CYC - 1);
  // Width of one failure status field
  localparam int unsigned FW = $bits(FAIL_NONE);

  overtemp_t ot_q;
  status_t status_d;
  mode_t mode_d;
  logic [CW-1:0] seq_cnt_q;
  logic [CW-1:0] seq_cnt_d;
  logic [SW-1:0] short_cnt_q;
  logic [OW-1:0] ov_cnt_q;
  logic third_ls_off_q;
  logic hs_lock_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ot_q <= '0;
    else
      ot_q <= overtemp_raw;
  end

  wire second_hot = ot_q.second_reg & second_reg_enable_q;
  wire third_hot = ot_q.third_reg & third_reg_on_q;
  wire can_hot = ot_q.can & can_tx_enable_q;
  wire [NUM_LIN-1:0] lin_hot = ot_q.lin & lin_tx_enable_q;
  wire hs_hot = |(ot_q.hs & highside_control_q);
  wire prewarn_hot = ot_q.prewarn & main_supply_on;
  // Device shutdown gated by main supply
  wire device_hot = ot_q.device & main_supply_on;
  wire any_stage_hot = second_hot | third_hot | can_hot | (|lin_hot) | hs_hot;
  // Raw condition, used for clear qualification
  wire stage_cond = ot_q.second_reg | ot_q.third_reg | ot_q.can | (|ot_q.lin) | (|ot_q.hs);
  wire device_event = device_hot & (mode_q == MODE_NORMAL);

  // Sticky flags: set beats clear, clear only when cool
  always_comb
  begin
    status_d = status_q;
    if (status_clear.stage_overtemp_flag && !stage_cond)
      status_d.stage_overtemp_flag = 1'b0;
    if (status_clear.temp_prewarn_flag && !ot_q.prewarn)
      status_d.temp_prewarn_flag = 1'b0;
    // Device flag clear in normal mode
    if (status_clear.device_overtemp_flag && !ot_q.device && mode_q == MODE_NORMAL)
      status_d.device_overtemp_flag = 1'b0;
    if (status_clear.second_reg_overtemp && !ot_q.second_reg)
      status_d.second_reg_overtemp = 1'b0;
    if (status_clear.third_reg_overtemp && !ot_q.third_reg)
      status_d.third_reg_overtemp = 1'b0;
    if (status_clear.highside_fault_status != '0 && !(|ot_q.hs))
      status_d.highside_fault_status = status_q.highside_fault_status & ~status_clear.highside_fault_status;
    if (any_stage_hot)
      status_d.stage_overtemp_flag = 1'b1;
    if (prewarn_hot)
      status_d.temp_prewarn_flag = 1'b1;
    if (device_hot)
      status_d.device_overtemp_flag = 1'b1;
    if (second_hot)
      status_d.second_reg_overtemp = 1'b1;
    if (third_hot)
      status_d.third_reg_overtemp = 1'b1;
    if (hs_hot)
      status_d.highside_fault_status = '1;
  end

  // Flags change only via set or qualified clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      status_q <= '0;
    else
      status_q <= status_d;
  end

  // Second regulator enable cleared on overtemp
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      second_reg_enable_q <= 1'b0;
    else if (second_hot)
      second_reg_enable_q <= 1'b0;
    else if (second_reg_enable_set)
      second_reg_enable_q <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      third_reg_enable_q <= 1'b0;
    else if (third_hot && !third_reg_load_share)
      third_reg_enable_q <= 1'b0;
    else if (third_reg_enable_set)
      third_reg_enable_q <= 1'b1;
  end

  // Load-sharing off while hot, back on when cool
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      third_ls_off_q <= 1'b0;
    else if (third_hot && third_reg_load_share)
      third_ls_off_q <= 1'b1;
    else if (!ot_q.third_reg || !third_reg_load_share)
      third_ls_off_q <= 1'b0;
  end

  // Third regulator actual state
  wire third_on_d = third_reg_enable_q & ~third_ls_off_q & ~(third_hot & third_reg_load_share)
    & ~(third_hot & ~third_reg_load_share);
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      third_reg_on_q <= 1'b0;
    else
      third_reg_on_q <= third_on_d;
  end

  // Trip lock until software writes all off
  // Without it the level copy would reapply the old setting one cycle later
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      hs_lock_q <= 1'b0;
    else if (hs_hot)
      hs_lock_q <= 1'b1;
    else if (highside_control_set == '0)
      hs_lock_q <= 1'b0;
  end

  // Any hot switch clears all controls
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      highside_control_q <= '0;
    else if (hs_hot || hs_lock_q)
      highside_control_q <= '0;
    else
      highside_control_q <= highside_control_set;
  end

  // CAN transmitter off while hot, field 01
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      can_tx_enable_q <= 1'b0;
      can_failure_status_q <= RESET_FAIL;
    end
    else
    begin
      can_tx_enable_q <= can_tx_request & ~ot_q.can;
      if (can_hot)
        can_failure_status_q <= FAIL_OVERTEMP;
      else if (can_fail_clear && !ot_q.can)
        can_failure_status_q <= FAIL_NONE;
    end
  end

  // LIN transmitters off while hot, field 01
  for (genvar i = 0; i < NUM_LIN; i++)
  begin : g_lin
    always_ff @(posedge clk_sys)
    begin
      if (srst)
      begin
        lin_tx_enable_q[i] <= 1'b0;
        lin_failure_status_q[FW*i +: FW] <= RESET_FAIL;
      end
      else
      begin
        lin_tx_enable_q[i] <= lin_tx_request[i] & ~ot_q.lin[i];
        if (lin_hot[i])
          lin_failure_status_q[FW*i +: FW] <= FAIL_OVERTEMP;
        else if (lin_fail_clear[i] && !ot_q.lin[i])
          lin_failure_status_q[FW*i +: FW] <= FAIL_NONE;
      end
    end
  end

  always_comb
  begin
    mode_d = mode_q;
    seq_cnt_d = seq_cnt_q;
    case (mode_q)
      MODE_NORMAL:
      begin
        seq_cnt_d = '0;
        if (device_event)
          mode_d = MODE_FAILSAFE;
      end
      MODE_FAILSAFE:
      begin
        seq_cnt_d = seq_cnt_q + CW'(1);
        if (seq_cnt_q == COOL_LAST)
        begin
          mode_d = MODE_RESTART;
          seq_cnt_d = '0;
        end
      end
      MODE_RESTART:
      begin
        seq_cnt_d = seq_cnt_q + CW'(1);
        if (seq_cnt_q == RESTART_LAST)
        begin
          mode_d = MODE_NORMAL;
          seq_cnt_d = '0;
        end
      end
      default:
      begin
        mode_d = MODE_NORMAL;
        seq_cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_q <= MODE_NORMAL;
      seq_cnt_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      seq_cnt_q <= seq_cnt_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || !main_supply_ov_raw)
    begin
      ov_cnt_q <= '0;
      main_supply_ov_q <= 1'b0;
    end
    else if (ov_cnt_q == OV_LAST)
      main_supply_ov_q <= 1'b1;
    else
      ov_cnt_q <= ov_cnt_q + OW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || !main_supply_below_reset_raw)
    begin
      short_cnt_q <= '0;
      main_supply_short_q <= 1'b0;
    end
    else if (short_cnt_q == SHORT_LAST)
      main_supply_short_q <= 1'b1;
    else
      short_cnt_q <= short_cnt_q + SW'(1);
  end
endmodule : thermal_protection_supervisor
`default_nettype wire

// ==== thermal_pkg.sv ====
/*
  Shared constants and carrier types for the thermal protection supervisor.
  Assumes a single 10 MHz system clock and synchronous reset.
*/
`default_nettype none
package thermal_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned CLK_PERIOD_NS = NS_PER_S / CLK_HZ;
  // Filter times as printed
  localparam int unsigned OV_FILTER_NS = 10_000;          // 10 us typical
  localparam int unsigned SHORT_FILTER_US = 4_000;        // 4 ms typical
  localparam int unsigned COOLDOWN_US = 100_000;          // cool-down, plain default
  localparam int unsigned RESTART_US = 2_000;             // restart dwell, plain default
  // Derived cycle counts
  localparam int unsigned OV_FILTER_CYC = (OV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_FILTER_CYC = SHORT_FILTER_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned COOLDOWN_CYC = COOLDOWN_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RESTART_CYC = RESTART_US * 1000 / CLK_PERIOD_NS;
  // Number of LIN stages and high-side switches
  localparam int unsigned NUM_LIN = 1;
  localparam int unsigned NUM_HS = 4;
  // Failure status field codes
  localparam logic [1:0] FAIL_NONE = 2'h0;
  localparam logic [1:0] FAIL_OVERTEMP = 2'h1;
  localparam logic [1:0] RESET_FAIL = 2'h0;

  // Operating mode request
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_FAILSAFE = 3'b010,
    MODE_RESTART = 3'b100
  } mode_t;

  // Overtemperature comparator bundle
  typedef struct packed {
    logic second_reg;
    logic third_reg;
    logic can;
    logic [NUM_LIN-1:0] lin;
    logic [NUM_HS-1:0] hs;
    logic prewarn;
    logic device;
  } overtemp_t;

  // Sticky status flags
  typedef struct packed {
    logic stage_overtemp_flag;
    logic device_overtemp_flag;
    logic temp_prewarn_flag;
    logic second_reg_overtemp;
    logic third_reg_overtemp;
    logic [NUM_HS-1:0] highside_fault_status;
  } status_t;
endpackage : thermal_pkg
`default_nettype wire

// ==== thermal_supervisor_assertions.sv ====
/*
  Port checker for the thermal protection supervisor.
  Assumes it is bound onto the top module; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module thermal_supervisor_checker
  import thermal_pkg::*;
#(
  parameter int unsigned COOLDOWN_CYCLES = 20,
  parameter int unsigned RESTART_CYCLES = 5,
  parameter int unsigned SHORT_CYCLES = 10
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire thermal_pkg::overtemp_t overtemp_raw,
  input wire logic main_supply_on,
  input wire logic main_supply_ov_raw,
  input wire logic main_supply_below_reset_raw,
  input wire thermal_pkg::status_t status_clear,
  input wire thermal_pkg::status_t status_q,
  input wire logic second_reg_enable_q,
  input wire logic [thermal_pkg::NUM_HS-1:0] highside_control_q,
  input wire logic can_tx_enable_q,
  input wire logic [1:0] can_failure_status_q,
  input wire thermal_pkg::mode_t mode_q,
  input wire logic main_supply_ov_q,
  input wire logic main_supply_short_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [31:0] dwell_q;
  logic [31:0] ov_run_q;
  logic [31:0] sc_run_q;
  mode_t mode_prev_q;
  // Time spent in the current mode and length of comparator runs
  always_ff @(posedge clk_sys)
  begin
    mode_prev_q <= mode_q;
    dwell_q <= (srst || mode_q != mode_prev_q) ? 32'h1 : dwell_q + 32'h1;
    ov_run_q <= main_supply_ov_raw ? ov_run_q + 32'h1 : 32'h0;
    sc_run_q <= main_supply_below_reset_raw ? sc_run_q + 32'h1 : 32'h0;
  end
  // Stage trips, gating, flag handling, shutdown sequence and filter lengths
  second_trip_a: assert property (
    overtemp_raw.second_reg ##1 second_reg_enable_q |=> !second_reg_enable_q && status_q.stage_overtemp_flag)
    else $error("second regulator trip missed");
  hs_all_off_a: assert property (
    |(overtemp_raw.hs & highside_control_q) ##1 |($past(overtemp_raw.hs) & highside_control_q)
    |=> highside_control_q == '0) else $error("switches left on");
  can_trip_a: assert property (
    overtemp_raw.can ##1 can_tx_enable_q |=> can_failure_status_q == FAIL_OVERTEMP && !can_tx_enable_q)
    else $error("transmitter trip missed");
  prewarn_set_a: assert property (
    overtemp_raw.prewarn && main_supply_on ##1 main_supply_on |=> status_q.temp_prewarn_flag)
    else $error("prewarning flag missed");
  device_entry_a: assert property (
    overtemp_raw.device && main_supply_on && mode_q == MODE_NORMAL ##1 main_supply_on && mode_q == MODE_NORMAL
    |=> mode_q == MODE_FAILSAFE && status_q.device_overtemp_flag) else $error("shutdown entry missed");
  failsafe_dwell_a: assert property (
    $past(mode_q) == MODE_FAILSAFE && mode_q != MODE_FAILSAFE |-> mode_q == MODE_RESTART
    && dwell_q >= COOLDOWN_CYCLES && dwell_q <= COOLDOWN_CYCLES + 1) else $error("cool-down length wrong");
  restart_dwell_a: assert property (
    $past(mode_q) == MODE_RESTART && mode_q != MODE_RESTART |-> mode_q == MODE_NORMAL
    && dwell_q >= RESTART_CYCLES && dwell_q <= RESTART_CYCLES + 1) else $error("restart length wrong");
  device_clear_a: assert property (
    $fell(status_q.device_overtemp_flag) |-> $past(status_clear.device_overtemp_flag)
    && $past(mode_q) == MODE_NORMAL && !$past(overtemp_raw.device, 2)) else $error("device flag lost");
  ov_filter_a: assert property (
    $rose(main_supply_ov_q) |-> ov_run_q >= OV_FILTER_CYC && ov_run_q <= OV_FILTER_CYC + 2)
    else $error("overvoltage filter length wrong");
  short_filter_a: assert property (
    $rose(main_supply_short_q) |-> sc_run_q >= SHORT_CYCLES && sc_run_q <= SHORT_CYCLES + 2)
    else $error("short filter length wrong");
  // Main scenarios reached
  cover property (mode_q == MODE_RESTART);
  cover property ($rose(main_supply_short_q));
  cover property (can_failure_status_q == FAIL_OVERTEMP);
endmodule : thermal_supervisor_checker
`default_nettype wire

// ==== clear_host_model.sv ====
/*
  Microcontroller stand-in that turns a clear request into one serial write.
  Assumes the bench raises a request for exactly one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module clear_host_model
  import thermal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire thermal_pkg::status_t clear_req,
  output var thermal_pkg::status_t status_clear
);
  always_ff @(posedge clk_sys)
  begin
    status_clear <= srst ? '0 : clear_req;
  end
endmodule : clear_host_model
`default_nettype wire

// ==== thermal_protection_supervisor_test.sv ====
/*
  Self-checking bench for the thermal protection supervisor.
  Assumes short cool-down, restart and short-filter counts set here.
*/
`timescale 1ns/1ps
`default_nettype none
module thermal_protection_supervisor_test;
  import thermal_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  overtemp_t ot = '0;
  logic ms_on = 1'b1;
  logic ov_raw = 1'b0;
  logic br_raw = 1'b0;
  logic ls = 1'b0;
  logic set2 = 1'b0;
  logic set3 = 1'b0;
  logic [3:0] hs_set = 4'h0;
  logic can_req = 1'b0;
  logic lin_req = 1'b0;
  logic can_clr = 1'b0;
  logic lin_clr = 1'b0;
  status_t clr_req = '0;
  status_t clr_pulse;
  status_t st;
  mode_t mode;
  logic en2, en3, on3, can_en, lin_en, ov_q, sc_q;
  logic [3:0] hs_q;
  logic [1:0] can_fs, lin_fs;
  int fail_count = 0;
  int n_compared = 0;
  int r, k, idx, lim;
  clear_host_model i_clear_host_model (.clk_sys, .srst, .clear_req(clr_req), .status_clear(clr_pulse));
  thermal_protection_supervisor #(.COOLDOWN_CYCLES(20), .RESTART_CYCLES(5), .SHORT_CYCLES(10))
  i_thermal_protection_supervisor (.clk_sys, .srst, .overtemp_raw(ot), .main_supply_on(ms_on),
    .main_supply_ov_raw(ov_raw), .main_supply_below_reset_raw(br_raw), .third_reg_load_share(ls),
    .second_reg_enable_set(set2), .third_reg_enable_set(set3), .highside_control_set(hs_set),
    .can_tx_request(can_req), .lin_tx_request(lin_req), .status_clear(clr_pulse), .can_fail_clear(can_clr),
    .lin_fail_clear(lin_clr), .status_q(st), .second_reg_enable_q(en2), .third_reg_enable_q(en3),
    .third_reg_on_q(on3), .highside_control_q(hs_q), .can_tx_enable_q(can_en), .lin_tx_enable_q(lin_en),
    .can_failure_status_q(can_fs), .lin_failure_status_q(lin_fs), .mode_q(mode), .main_supply_ov_q(ov_q),
    .main_supply_short_q(sc_q));
  // Clock, 100 ns period
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Switch state expected once one switch runs hot
  function automatic logic [3:0] hs_after(input logic [3:0] set, input int i);
    return set[i] ? 4'h0 : set;
  endfunction : hs_after
  // One clear write of every flag and failure field
  task automatic clr_all;
    clr_req = '1;
    can_clr = 1'b1;
    lin_clr = 1'b1;
    step(1);
    clr_req = '0;
    can_clr = 1'b0;
    lin_clr = 1'b0;
    step(2);
  endtask : clr_all
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial
  begin
    void'($urandom(32'h198c_e757));
    step(12);
    srst = 1'b0;
    step(1);
    chk("mode", MODE_NORMAL, mode);
    chk("status", 9'h0, st);
    ot.second_reg = 1'b1;
    step(3);
    chk("gated flag", 9'h0, st.second_reg_overtemp);
    ot.second_reg = 1'b0;
    set2 = 1'b1;
    step(1);
    set2 = 1'b0;
    step(2);
    ot.second_reg = 1'b1;
    step(3);
    chk("second enable", 9'h0, en2);
    chk("stage flag", 9'h1, st.stage_overtemp_flag);
    clr_all();
    chk("flag hot", 9'h1, st.stage_overtemp_flag);
    ot.second_reg = 1'b0;
    step(3);
    chk("second flag", 9'h1, st.second_reg_overtemp);
    clr_all();
    chk("stage flag", 9'h0, st.stage_overtemp_flag);
    $display("second regulator test done");
    can_req = 1'b1;
    lin_req = 1'b1;
    step(3);
    ot.can = 1'b1;
    ot.lin = 1'b1;
    step(3);
    chk("can tx", 9'h0, can_en);
    chk("can fail", FAIL_OVERTEMP, can_fs);
    chk("lin tx", 9'h0, lin_en);
    chk("lin fail", FAIL_OVERTEMP, lin_fs);
    ot.can = 1'b0;
    ot.lin = 1'b0;
    step(3);
    chk("can tx", 9'h1, can_en);
    chk("lin tx", 9'h1, lin_en);
    chk("can fail", FAIL_OVERTEMP, can_fs);
    clr_all();
    chk("can fail", FAIL_NONE, can_fs);
    $display("transmitter test done");
    for (r = 0; r < 4; r++)
    begin
      hs_set = 4'($urandom_range(15, 1));
      idx = $urandom_range(3, 0);
      step(3);
      ot.hs[idx] = 1'b1;
      step(3);
      chk("hs ctrl", hs_after(hs_set, idx), hs_q);
      chk("hs fault", hs_set[idx], |st.highside_fault_status);
      ot.hs = '0;
      hs_set = 4'h0;
      step(3);
      clr_all();
    end
    hs_set = 4'h0;
    $display("high-side test done");
    for (r = 1; r >= 0; r--)
    begin
      ls = r[0];
      set3 = 1'b1;
      step(1);
      set3 = 1'b0;
      step(2);
      ot.third_reg = 1'b1;
      step(3);
      chk("third on", 9'h0, on3);
      chk("third enable", ls, en3);
      chk("third flag", 9'h1, st.third_reg_overtemp);
      ot.third_reg = 1'b0;
      step(3);
      chk("third on", ls, on3);
      clr_all();
    end
    $display("third regulator test done");
    ms_on = 1'b0;
    ot.prewarn = 1'b1;
    ot.device = 1'b1;
    step(3);
    chk("prewarn", 9'h0, st.temp_prewarn_flag);
    chk("mode", MODE_NORMAL, mode);
    ms_on = 1'b1;
    step(3);
    chk("prewarn", 9'h1, st.temp_prewarn_flag);
    chk("mode", MODE_FAILSAFE, mode);
    chk("device flag", 9'h1, st.device_overtemp_flag);
    ot.prewarn = 1'b0;
    ot.device = 1'b0;
    step(3);
    clr_all();
    chk("device flag", 9'h1, st.device_overtemp_flag);
    chk("prewarn", 9'h0, st.temp_prewarn_flag);
    for (k = 0; k < 100 && mode !== MODE_NORMAL; k++)
      step(1);
    if (k == 100)
    begin
      fail_count++;
      give_verdict();
    end
    clr_all();
    chk("device flag", 9'h0, st.device_overtemp_flag);
    $display("thermal shutdown test done");
    for (r = 0; r < 2; r++)
    begin
      lim = r ? 10 : OV_FILTER_CYC;
      ov_raw = !r[0];
      br_raw = r[0];
      step(lim - 2);
      chk("filter early", 9'h0, r ? sc_q : ov_q);
      step(5);
      chk("filter late", 9'h1, r ? sc_q : ov_q);
      ov_raw = 1'b0;
      br_raw = 1'b0;
      step(2);
    end
    $display("filter test done");
    give_verdict();
  end
endmodule : thermal_protection_supervisor_test
bind thermal_protection_supervisor thermal_supervisor_checker #(.COOLDOWN_CYCLES(COOLDOWN_CYCLES),
  .RESTART_CYCLES(RESTART_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) i_chk (.clk_sys, .srst, .overtemp_raw,
  .main_supply_on, .main_supply_ov_raw, .main_supply_below_reset_raw, .status_clear, .status_q,
  .second_reg_enable_q, .highside_control_q, .can_tx_enable_q, .can_failure_status_q, .mode_q,
  .main_supply_ov_q, .main_supply_short_q);
`default_nettype wire
